/* File: lut_pair_pkg.sv */
`default_nettype none
package lut_pair_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [7:0] ADDR_CELL_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SEQ_CTRL = 8'h01;
   localparam logic [7:0] ADDR_T0_FIRST = 8'h05;
   localparam logic [7:0] ADDR_T0_SECOND = 8'h06;
   localparam logic [7:0] ADDR_T0_THIRD = 8'h07;
   localparam logic [7:0] ADDR_T0_TRUTH = 8'h08;
   localparam logic [7:0] ADDR_T1_FIRST = 8'h09;
   localparam logic [7:0] ADDR_T1_SECOND = 8'h0a;
   localparam logic [7:0] ADDR_T1_THIRD = 8'h0b;
   localparam logic [7:0] ADDR_T1_TRUTH = 8'h0c;
   localparam logic [7:0] ADDR_LIVE_STATUS = 8'h0d;

   // ==========================================================
   // field positions
   localparam int CELL_ENABLE_BIT = 0;
   localparam int TBL_ENABLE_BIT = 0;
   localparam int TBL_OUTEN_BIT = 3;
   localparam int TBL_FILT_LSB = 4;
   localparam int TBL_TABLE_CLOCK_SOURCE_SELECT_BIT = 6;
   localparam int TBL_EDGE_BIT = 7;
   localparam int SECOND_IN0_LSB = 0;
   localparam int SECOND_IN1_LSB = 4;
   localparam int THIRD_IN2_LSB = 0;
   localparam int SEQ_SEL_LSB = 0;

   // ==========================================================
   // writable bits and reset values
   localparam logic [7:0] CELL_CTRL_MASK = 8'h41;
   localparam logic [7:0] SEQ_CTRL_MASK = 8'h0f;
   localparam logic [7:0] FIRST_MASK = 8'hf9;
   localparam logic [7:0] SECOND_MASK = 8'hff;
   localparam logic [7:0] THIRD_MASK = 8'h0f;
   localparam logic [7:0] CELL_CTRL_RESET = 8'h00;
   localparam logic [7:0] SEQ_CTRL_RESET = 8'h00;
   localparam logic [7:0] TABLE_REG_RESET = 8'h00;

   // ==========================================================
   // output filter select codes
   localparam logic [1:0] FILT_OFF = 2'h0;
   localparam logic [1:0] FILT_SYNC = 2'h1;
   localparam logic [1:0] FILT_GLITCH = 2'h2;

   // ==========================================================
   // sequencer function select codes
   localparam logic [3:0] SEQ_OFF = 4'h0;
   localparam logic [3:0] SEQ_DFF = 4'h1;
   localparam logic [3:0] SEQ_JK = 4'h2;
   localparam logic [3:0] SEQ_DLATCH = 4'h3;
   localparam logic [3:0] SEQ_RS = 4'h4;

   // ==========================================================
   // input source select codes
   localparam logic [3:0] SRC_MASKED = 4'h0;
   localparam logic [3:0] SRC_FEEDBACK = 4'h1;
   localparam logic [3:0] SRC_LINK = 4'h2;
   localparam logic [3:0] SRC_EVENT_ZERO = 4'h3;
   localparam logic [3:0] SRC_EVENT_ONE = 4'h4;
   localparam logic [3:0] SRC_PIN = 4'h5;
   localparam logic [3:0] SRC_COMPARATOR = 4'h6;
   localparam logic [3:0] SRC_TIMER_WAVE = 4'h7;

   // ==========================================================
   // filter timing, in filter-clock edges
   localparam int FILT_SYNC_EDGES = 2;
   localparam int FILT_GLITCH_EDGES = 4;
endpackage
`default_nettype wire

/* File: lut_table_path.sv */
`timescale 1ns/1ps
`default_nettype none
module lut_table_path
   import lut_pair_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // configuration
   input wire logic i_enable,
   input wire logic i_tick,
   input wire logic [7:0] i_truth,
   input wire logic [1:0] i_filter_select,
   input wire logic i_edge_enable,
   // data
   input wire logic [2:0] i_inputs,
   output logic o_direct,
   output logic o_stage
);
   // ==========================================================
   // truth table
   logic [FILT_GLITCH_EDGES-1:0] shift_q;
   logic held_q;
   logic prev_q;
   logic pulse_q;
   logic agree;
   logic glitch_out;
   logic filt_out;

   assign o_direct = i_truth[i_inputs];

   // ==========================================================
   // filter: shift stages advance on filter-clock ticks only
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_q <= '0;
      end else if (!i_enable) begin
         shift_q <= '0;
      end else if (i_tick) begin
         shift_q <= {shift_q[FILT_GLITCH_EDGES-2:0], o_direct};
      end
   end

   // three equal samples are needed, so a spike of two edges never passes
   assign agree = (shift_q[3] == shift_q[2]) && (shift_q[2] == shift_q[1]);
   assign glitch_out = agree ? shift_q[3] : held_q;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         held_q <= 1'b0;
      end else if (!i_enable) begin
         held_q <= 1'b0;
      end else if (i_tick) begin
         held_q <= glitch_out;
      end
   end

   always_comb begin
      case (i_filter_select)
         FILT_SYNC: filt_out = shift_q[FILT_SYNC_EDGES-1];
         FILT_GLITCH: filt_out = glitch_out;
         default: filt_out = o_direct;
      endcase
   end

   // ==========================================================
   // rising edge detector, pulse lasts one reference cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_q <= 1'b0;
         pulse_q <= 1'b0;
      end else if (!i_enable) begin
         prev_q <= 1'b0;
         pulse_q <= 1'b0;
      end else if (i_tick) begin
         prev_q <= filt_out;
         pulse_q <= filt_out & ~prev_q;
      end else begin
         pulse_q <= 1'b0;
      end
   end

   // last enabled stage feeds the outside and the sequencer
   assign o_stage = i_edge_enable ? pulse_q : filt_out;
endmodule
`default_nettype wire

/* File: lut_pair_cell.sv */
// Notes on behaviour
// - table output is truth bit indexed by inputs, input 2 most significant
// - masked or unused inputs evaluate as low
// - each input picks masked, peripheral, event or internal submodule source
// - feedback source gives both tables the pair's stored sequencer state, flop or latch
// - link source gives table 0 table 1's output, and table 1 table 0's
// - two asynchronous event lines are selectable as inputs
// - pin source uses the dedicated pin of that table and input
// - inputs 0 and 1 chosen in second control, input 2 in third
// - without filter the output is combinational and may glitch
// - sync mode delays output by two filter-clock rising edges
// - glitch mode passes values held over three edges, lag four edges
// - filter state clears one cycle after the table is disabled
// - edge detect enable gives a pulse per rising edge; zero turns off
// - edge detector state clears one cycle after the table is disabled
// - one sequencer per pair, function chosen by its select field
// - sequencer takes each table's last enabled stage output
// - sequencer flop runs on the even table's filter clock, latch state on the reference clock
// - sequencer flip-flop changes only on sequencer clock rising edges, apart from the even table disable clear
// - even table disable clears latch and flop one cycle later; flop reset held one cycle longer
// - gated D flop: D even, gate odd; gate high loads, low holds
// - JK flop: J from even table, K from odd table
// - select codes: off, D flop, JK flop, D latch, RS latch
// - clock source bit uses input 2 as filter clock, low in truth
// - D latch: D even, gate odd; RS latch: S even, R odd
`timescale 1ns/1ps
`default_nettype none
module lut_pair_cell
   import lut_pair_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // external and internal sources
   input wire logic [5:0] i_lut_pin,
   input wire logic i_event_line_zero,
   input wire logic i_event_line_one,
   input wire logic i_comparator_out,
   input wire logic [2:0] i_timer_wave,
   // table outputs
   output logic [1:0] o_lut_out,
   output logic [1:0] o_pin_out,
   output logic [1:0] o_pin_oe
);
   // ==========================================================
   // declarations
   logic [7:0] cell_ctrl_q;
   logic [7:0] seq_ctrl_q;
   logic [7:0] first_q [0:1];
   logic [7:0] second_q [0:1];
   logic [7:0] third_q [0:1];
   logic [7:0] truth_q [0:1];
   logic [7:0] rdata_q;
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic [1:0] evt_s1_q;
   logic [1:0] evt_s2_q;
   logic [1:0] clk_prev_q;
   logic [1:0] tick;
   logic [1:0] tbl_en;
   logic [1:0] direct;
   logic [1:0] stage;
   logic [1:0] lut_val;
   logic [2:0] tbl_in [0:1];
   logic [2:0] raw_src [0:1];
   logic [3:0] seq_sel;
   logic seq_fb;
   logic seq_out;
   logic ff_q;
   logic latch_q;
   logic en0_prev_q;
   logic ff_rst_q;
   logic seq_d;
   logic seq_g;

   // ==========================================================
   // source selection shared by all six table inputs
   function automatic logic pick_source(
      input logic [3:0] sel,
      input logic fb,
      input logic link,
      input logic [1:0] evt,
      input logic pin,
      input logic cmp,
      input logic wave
   );
      logic val;
      val = 1'b0;
      case (sel)
         SRC_FEEDBACK: val = fb;
         SRC_LINK: val = link;
         SRC_EVENT_ZERO: val = evt[0];
         SRC_EVENT_ONE: val = evt[1];
         SRC_PIN: val = pin;
         SRC_COMPARATOR: val = cmp;
         SRC_TIMER_WAVE: val = wave;
         default: val = 1'b0;
      endcase
      return val;
   endfunction

   function automatic logic [3:0] input_select(input int idx, input logic [7:0] second,
      input logic [7:0] third);
      logic [3:0] sel;
      sel = third[THIRD_IN2_LSB +: 4];
      if (idx == 0) begin
         sel = second[SECOND_IN0_LSB +: 4];
      end else if (idx == 1) begin
         sel = second[SECOND_IN1_LSB +: 4];
      end
      return sel;
   endfunction

   // ==========================================================
   // register writes
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cell_ctrl_q <= CELL_CTRL_RESET;
         seq_ctrl_q <= SEQ_CTRL_RESET;
         for (int n = 0; n < 2; n++) begin
            first_q[n] <= TABLE_REG_RESET;
            second_q[n] <= TABLE_REG_RESET;
            third_q[n] <= TABLE_REG_RESET;
            truth_q[n] <= TABLE_REG_RESET;
         end
      end else if (i_reg_wr) begin
         if (i_reg_addr == ADDR_CELL_CTRL) begin
            cell_ctrl_q <= i_reg_wdata & CELL_CTRL_MASK;
         end else if (i_reg_addr == ADDR_SEQ_CTRL) begin
            seq_ctrl_q <= i_reg_wdata & SEQ_CTRL_MASK;
         end else if (i_reg_addr == ADDR_T0_FIRST) begin
            first_q[0] <= i_reg_wdata & FIRST_MASK;
         end else if (i_reg_addr == ADDR_T0_SECOND) begin
            second_q[0] <= i_reg_wdata & SECOND_MASK;
         end else if (i_reg_addr == ADDR_T0_THIRD) begin
            third_q[0] <= i_reg_wdata & THIRD_MASK;
         end else if (i_reg_addr == ADDR_T0_TRUTH) begin
            truth_q[0] <= i_reg_wdata;
         end else if (i_reg_addr == ADDR_T1_FIRST) begin
            first_q[1] <= i_reg_wdata & FIRST_MASK;
         end else if (i_reg_addr == ADDR_T1_SECOND) begin
            second_q[1] <= i_reg_wdata & SECOND_MASK;
         end else if (i_reg_addr == ADDR_T1_THIRD) begin
            third_q[1] <= i_reg_wdata & THIRD_MASK;
         end else if (i_reg_addr == ADDR_T1_TRUTH) begin
            truth_q[1] <= i_reg_wdata;
         end
      end
   end

   // ==========================================================
   // register reads, data stand one cycle after the strobe
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else if (i_reg_rd) begin
         if (i_reg_addr == ADDR_CELL_CTRL) begin
            rdata_q <= cell_ctrl_q;
         end else if (i_reg_addr == ADDR_SEQ_CTRL) begin
            rdata_q <= seq_ctrl_q;
         end else if (i_reg_addr == ADDR_T0_FIRST) begin
            rdata_q <= first_q[0];
         end else if (i_reg_addr == ADDR_T0_SECOND) begin
            rdata_q <= second_q[0];
         end else if (i_reg_addr == ADDR_T0_THIRD) begin
            rdata_q <= third_q[0];
         end else if (i_reg_addr == ADDR_T0_TRUTH) begin
            rdata_q <= truth_q[0];
         end else if (i_reg_addr == ADDR_T1_FIRST) begin
            rdata_q <= first_q[1];
         end else if (i_reg_addr == ADDR_T1_SECOND) begin
            rdata_q <= second_q[1];
         end else if (i_reg_addr == ADDR_T1_THIRD) begin
            rdata_q <= third_q[1];
         end else if (i_reg_addr == ADDR_T1_TRUTH) begin
            rdata_q <= truth_q[1];
         end else if (i_reg_addr == ADDR_LIVE_STATUS) begin
            rdata_q <= {5'h00, seq_out, lut_val};
         end else begin
            rdata_q <= 8'h00;
         end
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign o_reg_rdata = rdata_q;

   // ==========================================================
   // pin and event synchronisers; costs two cycles of latency on those paths
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
      end else begin
         pin_s1_q <= i_lut_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         evt_s1_q <= 2'h0;
         evt_s2_q <= 2'h0;
      end else begin
         evt_s1_q <= {i_event_line_one, i_event_line_zero};
         evt_s2_q <= evt_s1_q;
      end
   end

   // ==========================================================
   // table inputs
   always_comb begin
      for (int n = 0; n < 2; n++) begin
         for (int y = 0; y < 3; y++) begin
            raw_src[n][y] = pick_source(input_select(y, second_q[n], third_q[n]),
               seq_fb, direct[1-n], evt_s2_q, pin_s2_q[n*3+y], i_comparator_out,
               i_timer_wave[y]);
         end
         tbl_in[n] = raw_src[n];
         if (first_q[n][TBL_TABLE_CLOCK_SOURCE_SELECT_BIT]) begin
            tbl_in[n][2] = 1'b0;
         end
      end
   end

   // ==========================================================
   // filter clock: every cycle, or a rising edge of input 2's source
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clk_prev_q <= 2'h0;
      end else begin
         clk_prev_q <= {raw_src[1][2], raw_src[0][2]};
      end
   end

   always_comb begin
      for (int n = 0; n < 2; n++) begin
         tbl_en[n] = cell_ctrl_q[CELL_ENABLE_BIT] & first_q[n][TBL_ENABLE_BIT];
         tick[n] = 1'b1;
         if (first_q[n][TBL_TABLE_CLOCK_SOURCE_SELECT_BIT]) begin
            tick[n] = raw_src[n][2] & ~clk_prev_q[n];
         end
      end
   end

   // ==========================================================
   // the two tables
   for (genvar n = 0; n < 2; n++) begin : g_table
      lut_table_path u_path (
         .i_ref_clk(i_ref_clk),
         .i_rst_n(i_rst_n),
         .i_enable(tbl_en[n]),
         .i_tick(tick[n]),
         .i_truth(truth_q[n]),
         .i_filter_select(first_q[n][TBL_FILT_LSB +: 2]),
         .i_edge_enable(first_q[n][TBL_EDGE_BIT]),
         .i_inputs(tbl_in[n]),
         .o_direct(direct[n]),
         .o_stage(stage[n])
      );
   end

   // ==========================================================
   // sequencer
   assign seq_sel = seq_ctrl_q[SEQ_SEL_LSB +: 4];
   assign seq_d = stage[0];
   assign seq_g = stage[1];

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en0_prev_q <= 1'b0;
         ff_rst_q <= 1'b0;
      end else begin
         en0_prev_q <= tbl_en[0];
         ff_rst_q <= en0_prev_q & ~tbl_en[0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff_q <= 1'b0;
      end else if (!tbl_en[0] || ff_rst_q) begin
         ff_q <= 1'b0;
      end else if (tick[0]) begin
         if (seq_sel == SEQ_DFF) begin
            if (seq_g) begin
               ff_q <= seq_d;
            end
         end else if (seq_sel == SEQ_JK) begin
            case ({seq_d, seq_g})
               2'h1: ff_q <= 1'b0;
               2'h2: ff_q <= 1'b1;
               2'h3: ff_q <= ~ff_q;
               default: ff_q <= ff_q;
            endcase
         end
      end
   end

   // latch state follows the reference clock; transparency is combinational
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_q <= 1'b0;
      end else if (!tbl_en[0]) begin
         latch_q <= 1'b0;
      end else if (seq_sel == SEQ_DLATCH) begin
         if (seq_g) begin
            latch_q <= seq_d;
         end
      end else if (seq_sel == SEQ_RS) begin
         if (seq_d && !seq_g) begin
            latch_q <= 1'b1;
         end else if (seq_g && !seq_d) begin
            latch_q <= 1'b0;
         end
      end
   end

   always_comb begin
      seq_out = 1'b0;
      seq_fb = 1'b0;
      if (tbl_en[0]) begin
         case (seq_sel)
            SEQ_DFF, SEQ_JK: begin
               seq_out = ff_q;
               seq_fb = ff_q;
            end
            SEQ_DLATCH: begin
               seq_out = seq_g ? seq_d : latch_q;
               seq_fb = latch_q;
            end
            SEQ_RS: begin
               seq_out = latch_q;
               if (seq_d && !seq_g) begin
                  seq_out = 1'b1;
               end else if (seq_g && !seq_d) begin
                  seq_out = 1'b0;
               end
               seq_fb = latch_q;
            end
            default: begin
               seq_out = 1'b0;
               seq_fb = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // outputs; the even output carries the sequencer while one is selected
   always_comb begin
      lut_val = 2'h0;
      if (tbl_en[0]) begin
         lut_val[0] = (seq_sel == SEQ_OFF) ? stage[0] : seq_out;
      end
      if (tbl_en[1]) begin
         lut_val[1] = stage[1];
      end
   end

   assign o_lut_out = lut_val;
   assign o_pin_out = lut_val;
   assign o_pin_oe = {first_q[1][TBL_OUTEN_BIT] & tbl_en[1],
      first_q[0][TBL_OUTEN_BIT] & tbl_en[0]};
endmodule
`default_nettype wire

/* File: lut_pair_cell_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module lut_pair_cell_properties
   import lut_pair_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   // outputs
   input wire logic [1:0] o_lut_out,
   input wire logic [1:0] o_pin_out,
   input wire logic [1:0] o_pin_oe
);
   logic [7:0] truth_q;
   logic cell_en_q;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ==========================================================
   // shadows of what software wrote
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         truth_q <= 8'h00;
      end else if (i_reg_wr && i_reg_addr == ADDR_T0_TRUTH) begin
         truth_q <= i_reg_wdata;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cell_en_q <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == ADDR_CELL_CTRL) begin
         cell_en_q <= i_reg_wdata[CELL_ENABLE_BIT];
      end
   end
   // ==========================================================
   // assertions
   rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
      else $error("read data outside its slot");
   truth_readback_a: assert property (
      i_reg_rd && i_reg_addr == ADDR_T0_TRUTH |=> o_reg_rdata == truth_q)
      else $error("truth value read back wrong");
   unmapped_read_a: assert property (
      i_reg_rd && i_reg_addr > ADDR_LIVE_STATUS |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   third_mask_a: assert property (
      i_reg_rd && i_reg_addr == ADDR_T1_THIRD |=> (o_reg_rdata & ~THIRD_MASK) == 8'h00)
      else $error("third control spare bits set");
   cell_mask_a: assert property (
      i_reg_rd && i_reg_addr == ADDR_CELL_CTRL |=> (o_reg_rdata & ~CELL_CTRL_MASK) == 8'h00)
      else $error("cell control spare bits set");
   status_live_a: assert property (
      i_reg_rd && i_reg_addr == ADDR_LIVE_STATUS
      |=> o_reg_rdata[1] == $past(o_lut_out[1]) && o_reg_rdata[7:3] == 5'h00)
      else $error("status does not show table output");
   pin_mirror_a: assert property (
      o_pin_out == o_lut_out && (cell_en_q || o_lut_out == 2'b00))
      else $error("pin output not mirrored or not low while disabled");
   oe_gated_a: assert property (!cell_en_q |-> o_pin_oe == 2'b00)
      else $error("pin driven while cell disabled");
endmodule
bind lut_pair_cell lut_pair_cell_properties u_props (
   .i_ref_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
   .o_reg_rdata, .o_lut_out, .o_pin_out, .o_pin_oe
);
`default_nettype wire

/* File: lut_sources_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lut_sources_model (
   // pattern chosen by the bench
   input wire logic [11:0] i_want,
   // source lines toward the cell
   output logic [5:0] o_pin,
   output logic o_evt_zero,
   output logic o_evt_one,
   output logic o_cmp,
   output logic [2:0] o_wave
);
   // pins and events arrive unsynchronised; the cell owns the resync
   assign o_pin = i_want[5:0];
   assign o_evt_zero = i_want[6];
   assign o_evt_one = i_want[7];
   assign o_cmp = i_want[8];
   assign o_wave = i_want[11:9];
endmodule
`default_nettype wire

/* File: lut_pair_cell_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lut_pair_cell_tb
   import lut_pair_pkg::*;
;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] src_q = 12'h000;
   logic [7:0] reg_rdata, t0, t1;
   logic [5:0] pin;
   logic evt_zero, evt_one, cmp;
   logic [2:0] wave, ix;
   logic [1:0] lut_out, pin_out, pin_oe;
   logic [31:0] r;
   int bad_count = 0;
   int n_compared = 0;
   int q, a, b, pa, pb;

   lut_sources_model u_lut_sources_model (
      .i_want(src_q), .o_pin(pin), .o_evt_zero(evt_zero), .o_evt_one(evt_one),
      .o_cmp(cmp), .o_wave(wave)
   );
   lut_pair_cell u_lut_pair_cell (
      .i_ref_clk, .i_rst_n, .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_lut_pin(pin),
      .i_event_line_zero(evt_zero), .i_event_line_one(evt_one), .i_comparator_out(cmp),
      .i_timer_wave(wave), .o_lut_out(lut_out), .o_pin_out(pin_out), .o_pin_oe(pin_oe)
   );

   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   // ==========================================================
   // helpers
   function automatic int seqm(int m, int q, int a, int b);
      case (m)
         SEQ_DFF, SEQ_DLATCH: return b ? a : q;
         SEQ_JK: return (a & b) ? 1 - q : (a ? 1 : (b ? 0 : q));
         default: return a ? 1 : (b ? 0 : q);
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge i_ref_clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge i_ref_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge i_ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task automatic drv(input logic [11:0] v);
      @(posedge i_ref_clk);
      src_q <= v;
      #1;
   endtask
   task automatic report_and_stop();
      $display("compared=%0d mismatches=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #60us;
      bad_count++;
      report_and_stop();
   end

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(29374));
      repeat (5) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      rd(ADDR_CELL_CTRL, CELL_CTRL_RESET);
      wr(ADDR_CELL_CTRL, 8'hff);
      rd(ADDR_CELL_CTRL, CELL_CTRL_MASK);
      wr(ADDR_T1_THIRD, 8'hf7);
      rd(ADDR_T1_THIRD, 8'h07);
      rd(8'h20, 8'h00);
      wr(ADDR_T0_SECOND, 8'h76);
      wr(ADDR_T1_SECOND, 8'h76);
      wr(ADDR_T0_THIRD, 8'h07);
      wr(ADDR_T0_FIRST, 8'h09);
      wr(ADDR_T1_FIRST, 8'h09);
      $display("done: registers");
      // inputs are {wave2, wave1, comparator}; input 2 masked in the second half
      for (int k = 0; k < 16; k++) begin
         if (k == 8) begin
            wr(ADDR_T0_THIRD, 8'h00);
            wr(ADDR_T1_THIRD, 8'h00);
         end
         r = $urandom;
         t0 = r[15:8];
         t1 = r[23:16];
         wr(ADDR_T0_TRUTH, t0);
         wr(ADDR_T1_TRUTH, t1);
         ix = k[2:0];
         drv({ix[2:1], r[0], ix[0], r[7:0]});
         if (k >= 8) ix[2] = 1'b0;
         chk(lut_out[0], t0[ix]);
         chk(lut_out[1], t1[ix]);
      end
      rd(ADDR_T0_TRUTH, t0);
      rd(ADDR_LIVE_STATUS, {6'h00, t1[ix], t0[ix]});
      $display("done: truth");
      wr(ADDR_T0_TRUTH, 8'haa);
      wr(ADDR_T1_TRUTH, 8'haa);
      wr(ADDR_T0_SECOND, 8'h72);
      for (int k = 0; k < 4; k++) begin
         r = $urandom;
         drv(r[11:0]);
         chk(lut_out[0], r[8]);
      end
      wr(ADDR_T0_SECOND, 8'h76);
      for (int s = 3; s < 6; s++) begin
         wr(ADDR_T1_SECOND, 8'h70 | s[7:0]);
         for (int k = 0; k < 3; k++) begin
            r = $urandom;
            drv(r[11:0]);
            step(3);
            chk(lut_out[1], (s == 5) ? r[3] : r[s + 3]);
         end
      end
      wr(ADDR_T1_SECOND, 8'h76);
      $display("done: sources");
      wr(ADDR_T1_FIRST, 8'h19);
      drv(12'h000);
      step(4);
      drv(12'h100);
      step(1);
      chk(lut_out[1], 1'b0);
      step(1);
      chk(lut_out[1], 1'b1);
      wr(ADDR_T1_FIRST, 8'h29);
      drv(12'h000);
      step(6);
      drv(12'h100);
      drv(12'h000);
      for (int k = 0; k < 6; k++) begin
         step(1);
         chk(lut_out[1], 1'b0);
      end
      drv(12'h100);
      step(3);
      chk(lut_out[1], 1'b0);
      step(1);
      chk(lut_out[1], 1'b1);
      // a table left full of ones must restart empty
      wr(ADDR_T1_FIRST, 8'h28);
      drv(12'h000);
      step(2);
      wr(ADDR_T1_FIRST, 8'h29);
      for (int k = 0; k < 5; k++) begin
         step(1);
         chk(lut_out[1], 1'b0);
      end
      wr(ADDR_T1_FIRST, 8'h99);
      step(6);
      drv(12'h100);
      // two sync edges, then one edge for the detector register
      step(3);
      chk(lut_out[1], 1'b1);
      step(1);
      chk(lut_out[1], 1'b0);
      step(4);
      chk(lut_out[1], 1'b0);
      $display("done: filters");
      wr(ADDR_T1_FIRST, 8'h09);
      wr(ADDR_T1_TRUTH, 8'hcc);
      for (int m = 1; m < 5; m++) begin
         drv(12'h000);
         wr(ADDR_T0_FIRST, 8'h08);
         wr(ADDR_SEQ_CTRL, m[7:0]);
         step(2);
         chk(lut_out[0], 1'b0);
         wr(ADDR_T0_FIRST, 8'h09);
         step(2);
         q = 0;
         pa = 0;
         pb = 0;
         for (int k = 0; k < 12; k++) begin
            r = $urandom;
            a = int'(r[0]);
            b = (m == 4 && a == 1) ? 0 : int'(r[1]);
            drv({1'b0, b[0], 1'b0, a[0], 8'h00});
            q = (m < 3) ? seqm(m, q, pa, pb) : seqm(m, q, a, b);
            chk(lut_out[0], q[7:0]);
            pa = a;
            pb = b;
         end
      end
      $display("done: sequencer");
      // toggle flop: D is inverted feedback unless input 2 leaks, gate high, clock input 2
      wr(ADDR_T0_FIRST, 8'h08);
      wr(ADDR_SEQ_CTRL, 8'h01);
      wr(ADDR_T0_SECOND, 8'h71);
      wr(ADDR_T0_THIRD, 8'h07);
      wr(ADDR_T0_TRUTH, 8'h05);
      wr(ADDR_T1_TRUTH, 8'hff);
      wr(ADDR_T0_FIRST, 8'h49);
      q = 0;
      for (int k = 0; k < 4; k++) begin
         drv(12'h800);
         chk(lut_out[0], q[7:0]);
         step(1);
         q = 1 - q;
         chk(lut_out[0], q[7:0]);
         drv(12'h000);
         chk(lut_out[0], q[7:0]);
      end
      $display("done: feedback");
      report_and_stop();
   end
endmodule
`default_nettype wire
